// *** pkg/pcpm_pkg.sv ***
package pcpm_pkg;

  // ----------------------------------------------------------------
  // Widths and field layout
  // ----------------------------------------------------------------
  localparam int unsigned PCPM_PC_W = 24;
  localparam int unsigned PCPM_ADDR_W = 18;
  localparam int unsigned PCPM_UPPER_LSB = 16;
  localparam int unsigned PCPM_UPPER_W = 8;
  localparam int unsigned PCPM_LOWER_W = 16;
  localparam int unsigned PCPM_CLEAR_BIT = 0;

  // ----------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [15:0] PCPM_IDX_CLEAR = 16'hF462;
  localparam logic [15:0] PCPM_IDX_FRAME_HIGH = 16'hF463;
  localparam logic [15:0] PCPM_IDX_FRAME_LOW = 16'hF464;
  localparam logic [15:0] PCPM_IDX_ALLTIME_HIGH = 16'hF465;
  localparam logic [15:0] PCPM_IDX_ALLTIME_LOW = 16'hF466;

  localparam logic [17:0] PCPM_ADDR_CLEAR = {PCPM_IDX_CLEAR, 2'h0};
  localparam logic [17:0] PCPM_ADDR_FRAME_HIGH = {PCPM_IDX_FRAME_HIGH, 2'h0};
  localparam logic [17:0] PCPM_ADDR_FRAME_LOW = {PCPM_IDX_FRAME_LOW, 2'h0};
  localparam logic [17:0] PCPM_ADDR_ALLTIME_HIGH = {PCPM_IDX_ALLTIME_HIGH, 2'h0};
  localparam logic [17:0] PCPM_ADDR_ALLTIME_LOW = {PCPM_IDX_ALLTIME_LOW, 2'h0};

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [23:0] PCPM_PEAK_RST = 24'h000000;
  localparam logic PCPM_CLEAR_RST = 1'b0;
  localparam logic [31:0] PCPM_DATA_RST = 32'h00000000;

  // ----------------------------------------------------------------
  // Bus slave states
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    PCPM_APB_IDLE = 1'b0,
    PCPM_APB_ACK = 1'b1
  } pcpm_apb_state_t;

endpackage

// *** verilog/pcpm_peak_tracker.sv ***
`timescale 1ns/1ns
module pcpm_peak_tracker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [23:0] pc_value,
  input wire logic pc_valid,
  input wire logic frame_boundary,
  input wire logic clear,
  output logic [23:0] frame_peak,
  output logic [23:0] alltime_peak
);

  // ----------------------------------------------------------------
  // Peak tracking
  // ----------------------------------------------------------------
  logic [23:0] running_peak;
  logic [23:0] next_running_peak;
  logic [23:0] next_frame_peak;
  logic [23:0] next_alltime_peak;
  logic [23:0] sample;
  logic [23:0] running_now;

  always_comb begin
    sample = pc_valid ? pc_value : pcpm_pkg::PCPM_PEAK_RST;
    // The boundary cycle's own sample still belongs to the closing frame.
    running_now = (sample > running_peak) ? sample : running_peak;
    next_running_peak = running_now;
    next_frame_peak = frame_peak;
    next_alltime_peak = alltime_peak;
    if (clear) begin
      // While clear is held every figure stays at zero and nothing updates.
      next_running_peak = pcpm_pkg::PCPM_PEAK_RST;
      next_frame_peak = pcpm_pkg::PCPM_PEAK_RST;
      next_alltime_peak = pcpm_pkg::PCPM_PEAK_RST;
    end else if (frame_boundary) begin
      next_frame_peak = running_now;
      next_running_peak = pcpm_pkg::PCPM_PEAK_RST;
      if (running_now > alltime_peak) begin
        next_alltime_peak = running_now;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      running_peak <= pcpm_pkg::PCPM_PEAK_RST;
      frame_peak <= pcpm_pkg::PCPM_PEAK_RST;
      alltime_peak <= pcpm_pkg::PCPM_PEAK_RST;
    end else begin
      running_peak <= next_running_peak;
      frame_peak <= next_frame_peak;
      alltime_peak <= next_alltime_peak;
    end
  end

endmodule

// *** verilog/pcpm_monitor.sv ***
`timescale 1ns/1ns
module pcpm_monitor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [23:0] pc_value,
  input wire logic pc_valid,
  input wire logic frame_boundary,
  output logic pc_clear
);

  // ----------------------------------------------------------------
  // Peak figures
  // ----------------------------------------------------------------
  logic [23:0] frame_peak;
  logic [23:0] alltime_peak;

  pcpm_peak_tracker u_tracker (
    .clk_sys(clk_sys),
    .rst(rst),
    .pc_value(pc_value),
    .pc_valid(pc_valid),
    .frame_boundary(frame_boundary),
    .clear(pc_clear),
    .frame_peak(frame_peak),
    .alltime_peak(alltime_peak)
  );

  // ----------------------------------------------------------------
  // Address decode and read data
  // ----------------------------------------------------------------
  logic addr_hit;
  logic [31:0] read_word;

  always_comb begin
    addr_hit = 1'b1;
    read_word = pcpm_pkg::PCPM_DATA_RST;
    unique case (paddr)
      pcpm_pkg::PCPM_ADDR_CLEAR: begin
        read_word[pcpm_pkg::PCPM_CLEAR_BIT] = pc_clear;
      end
      pcpm_pkg::PCPM_ADDR_FRAME_HIGH: begin
        read_word[pcpm_pkg::PCPM_UPPER_W-1:0] =
          frame_peak[pcpm_pkg::PCPM_PC_W-1:pcpm_pkg::PCPM_UPPER_LSB];
      end
      pcpm_pkg::PCPM_ADDR_FRAME_LOW: begin
        read_word[pcpm_pkg::PCPM_LOWER_W-1:0] =
          frame_peak[pcpm_pkg::PCPM_LOWER_W-1:0];
      end
      pcpm_pkg::PCPM_ADDR_ALLTIME_HIGH: begin
        read_word[pcpm_pkg::PCPM_UPPER_W-1:0] =
          alltime_peak[pcpm_pkg::PCPM_PC_W-1:pcpm_pkg::PCPM_UPPER_LSB];
      end
      pcpm_pkg::PCPM_ADDR_ALLTIME_LOW: begin
        read_word[pcpm_pkg::PCPM_LOWER_W-1:0] =
          alltime_peak[pcpm_pkg::PCPM_LOWER_W-1:0];
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Bus slave and clear control
  // ----------------------------------------------------------------
  pcpm_pkg::pcpm_apb_state_t state;
  pcpm_pkg::pcpm_apb_state_t next_state;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_prdata;
  logic next_pc_clear;

  // The answer is prepared in the setup cycle so that pready, prdata and
  // pslverr all come straight from flip-flops with no wait state.
  always_comb begin
    next_state = state;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = pcpm_pkg::PCPM_DATA_RST;
    next_pc_clear = pc_clear;
    unique case (state)
      pcpm_pkg::PCPM_APB_IDLE: begin
        if (psel && !penable) begin
          next_state = pcpm_pkg::PCPM_APB_ACK;
          next_pready = 1'b1;
          next_pslverr = !addr_hit;
          next_prdata = pwrite ? pcpm_pkg::PCPM_DATA_RST : read_word;
        end
      end
      pcpm_pkg::PCPM_APB_ACK: begin
        next_state = pcpm_pkg::PCPM_APB_IDLE;
        // Peak words are read-only; writes to them are dropped silently.
        if (psel && penable && pwrite && (paddr == pcpm_pkg::PCPM_ADDR_CLEAR) &&
            pstrb[0]) begin
          next_pc_clear = pwdata[pcpm_pkg::PCPM_CLEAR_BIT];
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= pcpm_pkg::PCPM_APB_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= pcpm_pkg::PCPM_DATA_RST;
      pc_clear <= pcpm_pkg::PCPM_CLEAR_RST;
    end else begin
      state <= next_state;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
      pc_clear <= next_pc_clear;
    end
  end

endmodule

// *** verification/pcpm_monitor_assertions.sv ***
`timescale 1ns/1ns
module pcpm_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pc_clear
);
  // ------------------------------------------
  // Address decode and bus checks
  // ------------------------------------------
  logic hi, lo, clr;
  assign hi = paddr == pcpm_pkg::PCPM_ADDR_FRAME_HIGH || paddr == pcpm_pkg::PCPM_ADDR_ALLTIME_HIGH;
  assign lo = paddr == pcpm_pkg::PCPM_ADDR_FRAME_LOW || paddr == pcpm_pkg::PCPM_ADDR_ALLTIME_LOW;
  assign clr = paddr == pcpm_pkg::PCPM_ADDR_CLEAR;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  AST_RDY: assert property (psel && !penable |=> pready)
    else $error("no answer");
  AST_PULSE: assert property (pready |=> !pready)
    else $error("long answer");
  AST_MAP: assert property (pready |-> pslverr == !(hi || lo || clr))
    else $error("wrong error flag");
  AST_IDLE: assert property (!pready || pslverr |-> prdata == 32'h0)
    else $error("stray read data");
  AST_UP: assert property (pready && !pwrite && hi |-> prdata[31:8] == 24'h0)
    else $error("upper word wide");
  AST_LO: assert property (pready && !pwrite && lo |-> prdata[31:16] == 16'h0)
    else $error("lower word wide");
  AST_SET: assert property (pready && pwrite && clr && pstrb[0] |=>
    pc_clear == $past(pwdata[0]))
    else $error("clear bit not written");
  AST_HOLD: assert property (!(pready && pwrite && clr) |=> $stable(pc_clear))
    else $error("clear bit moved");
  AST_ZERO: assert property (pc_clear && $past(pc_clear) && $past(pc_clear, 2) &&
    pready && !pwrite && (hi || lo) |-> prdata == 32'h0)
    else $error("peak not cleared");
endmodule
bind pcpm_monitor pcpm_chk i_pcpm_chk (.clk_sys(clk_sys), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pc_clear(pc_clear));

// *** verification/tb_program_counter_peak_monitor.sv ***
`timescale 1ns/1ns
module tb_program_counter_peak_monitor;
  logic clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, pc_clear, pc_valid = 1'b0, frame_boundary = 1'b0;
  logic [23:0] pc_value = 24'h0;
  int fails = 0, tests_run = 0;
  always #10 clk_sys = ~clk_sys;
  pcpm_monitor i_pcpm_monitor (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pc_value(pc_value), .pc_valid(pc_valid),
    .frame_boundary(frame_boundary), .pc_clear(pc_clear));
  // ------------------------------------------
  // Bus and core-side tasks
  // ------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      fails++;
      end_sim();
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task automatic rdc(input string nm, input logic [17:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(nm, rd, exp);
    chk(nm, {31'h0, er}, 32'h0);
  endtask
  task automatic pc(input logic [23:0] v, input logic vl, input logic b);
    pc_value <= v;
    pc_valid <= vl;
    frame_boundary <= b;
    @(posedge clk_sys);
  endtask
  task automatic peaks(input logic [23:0] f, input logic [23:0] m);
    rdc("frame_peak_high", pcpm_pkg::PCPM_ADDR_FRAME_HIGH, {24'h0, f[23:16]});
    rdc("frame_peak_low", pcpm_pkg::PCPM_ADDR_FRAME_LOW, {16'h0, f[15:0]});
    rdc("alltime_peak_high", pcpm_pkg::PCPM_ADDR_ALLTIME_HIGH, {24'h0, m[23:16]});
    rdc("alltime_peak_low", pcpm_pkg::PCPM_ADDR_ALLTIME_LOW, {16'h0, m[15:0]});
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    peaks(24'h0, 24'h0);
    rdc("clear", pcpm_pkg::PCPM_ADDR_CLEAR, 32'h0);
    pc(24'h123456, 1'b1, 1'b0);
    pc(24'hFFFFFF, 1'b0, 1'b0);
    pc(24'h12345A, 1'b1, 1'b1);
    pc(24'h00ABCD, 1'b1, 1'b0);
    pc(24'h000001, 1'b1, 1'b1);
    pc(24'h0, 1'b0, 1'b0);
    peaks(24'h00ABCD, 24'h12345A);
    pc(24'h0, 1'b0, 1'b1);
    pc(24'h0, 1'b0, 1'b0);
    apb(1'b1, pcpm_pkg::PCPM_ADDR_FRAME_LOW, 32'hFFFFFFFF, 4'hF);
    apb(1'b1, pcpm_pkg::PCPM_ADDR_ALLTIME_HIGH, 32'hFFFFFFFF, 4'hF);
    peaks(24'h0, 24'h12345A);
    apb(1'b0, 18'h3D99C, 32'h0, 4'h0);
    chk("unmapped", {31'h0, er}, 32'h1);
    chk("unmapped_data", rd, 32'h0);
    apb(1'b0, pcpm_pkg::PCPM_ADDR_FRAME_LOW + 18'h1, 32'h0, 4'h0);
    chk("misaligned", {31'h0, er}, 32'h1);
    apb(1'b1, pcpm_pkg::PCPM_ADDR_CLEAR, 32'h1, 4'h0);
    chk("pc_clear", {31'h0, pc_clear}, 32'h0);
    apb(1'b1, pcpm_pkg::PCPM_ADDR_CLEAR, 32'h1, 4'h1);
    chk("pc_clear", {31'h0, pc_clear}, 32'h1);
    pc(24'h00FFFF, 1'b1, 1'b1);
    pc(24'h0, 1'b0, 1'b0);
    peaks(24'h0, 24'h0);
    rdc("clear", pcpm_pkg::PCPM_ADDR_CLEAR, 32'h1);
    apb(1'b1, pcpm_pkg::PCPM_ADDR_CLEAR, 32'h0, 4'h1);
    chk("pc_clear", {31'h0, pc_clear}, 32'h0);
    pc(24'h000300, 1'b1, 1'b1);
    pc(24'h0, 1'b0, 1'b0);
    peaks(24'h000300, 24'h000300);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    peaks(24'h0, 24'h0);
    end_sim();
  end
endmodule
